// ---- core/fpi_pkg.sv ----
// constants and types for the front panel indicator block
`default_nettype none
package fpi_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [11:0] FPI_CTRL_OFF = 12'h000;
   localparam logic [11:0] FPI_STAT_OFF = 12'h004;
   localparam logic [11:0] FPI_IRQ_STAT_OFF = 12'h008;
   localparam logic [11:0] FPI_IRQ_MASK_OFF = 12'h00C;

   // ==========================================================
   // field positions
   localparam int FPI_CTRL_PROT_BIT = 0;
   localparam int FPI_CTRL_UNIT_LSB = 4;
   localparam int FPI_IRQ_ERR_BIT = 0;
   localparam int FPI_IRQ_DCF_BIT = 1;
   localparam int FPI_IRQ_BAD_BIT = 2;
   localparam int FPI_IRQ_CLR_BIT = 3;
   localparam int FPI_IRQ_W = 4;

   // ==========================================================
   // reset values
   localparam logic [7:0] FPI_CTRL_RST = 8'h00;
   localparam logic [3:0] FPI_IRQ_RST = 4'h0;

   // ==========================================================
   // display codes
   localparam logic [7:0] FPI_CODE_MIN = 8'h20;
   localparam logic [7:0] FPI_CODE_MAX = 8'hDD;
   localparam logic [3:0] FPI_DIGIT_MAX = 4'hE;
   localparam logic [3:0] FPI_HALT_DIGIT = 4'hF;
   localparam logic [6:0] FPI_SEG_BLANK = 7'h00;
   localparam int FPI_DIGITS = 3;

   // ==========================================================
   // panel pin indices
   localparam int FPI_PIN_PERMIT = 0;
   localparam int FPI_PIN_AC = 1;
   localparam int FPI_PIN_DC = 2;
   localparam int FPI_PIN_PWR = 3;
   localparam int FPI_PIN_SELA = 4;
   localparam int FPI_PIN_SELB = 5;
   localparam int FPI_PIN_SRST = 6;
   localparam int FPI_PIN_W = 7;

   typedef enum logic [1:0] {
      FPI_ERR_IDLE = 2'h0,
      FPI_ERR_SOFT = 2'h1,
      FPI_ERR_HARD = 2'h3
   } fpi_err_state_t;

endpackage
`default_nettype wire

// ---- core/fpi_panel.sv ----
// front panel lamps and digit display with apb register slave
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - protect lamp is dark whenever writing is permitted and the ctrl protect bit is clear.
// - permit switch in write-enable keeps protect lamp off while the ctrl protect bit is clear.
// - power fault lamp lit with ac present and switch off.
// - lamp lit with switch on marks latched dc fault until switch cycled.
// - unit lamp lit means unit mode, digits show unit number.
// - unit lamp dark means cylinder mode, digits show cylinder while no error is shown.
// - display mode follows the two display select switches.
// - error lamp lights when an error event with a valid code arrives.
// - controller soft reset clears a soft error.
// - hard error stays lit through soft reset.
// - error lamp lit means error code shown on digits.
// - error lamp off with no error pending.
// - three seven-segment digits are driven.
// - error codes use digits 0 to E within 20 to DD.
// - shutdown halt shows F on the unit digit in unit mode or while an error is shown.
module fpi_panel
   import fpi_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_write_permit,
   input wire logic i_ac_power_ok,
   input wire logic i_dc_power_ok,
   input wire logic i_power_switch_on,
   input wire logic i_display_select_switch_a,
   input wire logic i_display_select_switch_b,
   input wire logic i_ctl_soft_reset,
   input wire logic i_err_event,
   input wire logic i_err_hard,
   input wire logic [7:0] i_err_code,
   input wire logic i_shutdown_halt,
   input wire logic [11:0] i_cylinder,
   output logic o_protect_lamp,
   output logic o_power_fault_lamp,
   output logic o_unit_mode_lamp,
   output logic o_error_lamp,
   output logic [6:0] o_seg_unit,
   output logic [6:0] o_seg_status_hi,
   output logic [6:0] o_seg_status_lo,
   output logic o_irq
);

   // ==========================================================
   // functions
   localparam logic [6:0] SEG_TAB [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
      7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

   function automatic logic [6:0] hex_to_seg(input logic [3:0] n);
      return SEG_TAB[n];
   endfunction

   function automatic logic code_ok(input logic [7:0] c);
      return (c >= FPI_CODE_MIN) && (c <= FPI_CODE_MAX)
         && (c[7:4] <= FPI_DIGIT_MAX) && (c[3:0] <= FPI_DIGIT_MAX);
   endfunction
   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   assign rst_n = rst_sync_q[1];

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // panel pin synchronisers
   logic [FPI_PIN_W-1:0] pin_w;
   logic [FPI_PIN_W-1:0] s1_q;
   logic [FPI_PIN_W-1:0] s2_q;
   logic [FPI_PIN_W-1:0] s3_q;
   logic [FPI_PIN_W-1:0] pin_q;
   logic [FPI_PIN_W-1:0] pin_d;

   assign pin_w = {i_ctl_soft_reset, i_display_select_switch_b,
      i_display_select_switch_a, i_power_switch_on, i_dc_power_ok,
      i_ac_power_ok, i_write_permit};
   // accept a level once two later stages agree
   assign pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
      end
      else
      begin
         s1_q <= pin_w;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   logic permit_w;
   logic ac_w;
   logic dc_w;
   logic pwr_w;
   logic unit_mode_w;
   logic srst_prev_q;
   logic soft_pulse_w;

   assign permit_w = pin_q[FPI_PIN_PERMIT];
   assign ac_w = pin_q[FPI_PIN_AC];
   assign dc_w = pin_q[FPI_PIN_DC];
   assign pwr_w = pin_q[FPI_PIN_PWR];
   assign unit_mode_w = pin_q[FPI_PIN_SELA] & ~pin_q[FPI_PIN_SELB];
   assign soft_pulse_w = pin_q[FPI_PIN_SRST] & ~srst_prev_q;

   // ==========================================================
   // registers and apb decode
   logic [7:0] ctrl_q;
   logic [FPI_IRQ_W-1:0] istat_q;
   logic [FPI_IRQ_W-1:0] istat_d;
   logic [FPI_IRQ_W-1:0] imask_q;
   logic [FPI_IRQ_W-1:0] iset_w;
   logic wr_w;
   logic setup_w;
   logic mapped_w;
   logic [31:0] rd_w;
   logic [31:0] stat_w;
   logic [3:0] unit_num_w;

   assign setup_w = i_psel & ~i_penable;
   assign wr_w = i_psel & i_penable & i_pwrite & o_pready;
   assign mapped_w = addr_hit(i_paddr, FPI_CTRL_OFF) | addr_hit(i_paddr, FPI_STAT_OFF)
      | addr_hit(i_paddr, FPI_IRQ_STAT_OFF) | addr_hit(i_paddr, FPI_IRQ_MASK_OFF);
   assign unit_num_w = ctrl_q[FPI_CTRL_UNIT_LSB +: 4];

   // ==========================================================
   // error state
   fpi_err_state_t err_q;
   fpi_err_state_t err_d;
   logic [7:0] code_q;
   logic [7:0] code_d;
   logic ev_ok_w;
   logic dcf_q;
   logic dcf_d;

   assign ev_ok_w = i_err_event & code_ok(i_err_code);
   always_comb
   begin
      err_d = err_q;
      code_d = code_q;
      case (err_q)
         FPI_ERR_IDLE, FPI_ERR_SOFT:
         begin
            if (ev_ok_w)
            begin
               err_d = i_err_hard ? FPI_ERR_HARD : FPI_ERR_SOFT;
               code_d = i_err_code;
            end
            else if (soft_pulse_w)
               err_d = FPI_ERR_IDLE;
         end
         FPI_ERR_HARD:
         begin
            if (ev_ok_w && i_err_hard)
               code_d = i_err_code;
            err_d = FPI_ERR_HARD;
         end
         default:
            err_d = FPI_ERR_IDLE;
      endcase
   end
   // latched dc fault, cleared only by switching power off
   assign dcf_d = pwr_w & (dcf_q | (ac_w & ~dc_w));

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         err_q <= FPI_ERR_IDLE;
         code_q <= 8'h00;
         dcf_q <= 1'b0;
         srst_prev_q <= 1'b0;
      end
      else
      begin
         err_q <= err_d;
         code_q <= code_d;
         dcf_q <= dcf_d;
         srst_prev_q <= pin_q[FPI_PIN_SRST];
      end
   end

   sequence s_err_lit;
      (err_q != FPI_ERR_IDLE) ##1 o_error_lamp;
   endsequence
   sequence s_err_dark;
      (err_q == FPI_ERR_IDLE) ##1 !o_error_lamp;
   endsequence
   a_err_sets_lamp: assert property (ev_ok_w |=> s_err_lit)
      else $error("error event did not light lamp");
   a_soft_clears: assert property ((err_q == FPI_ERR_SOFT) && soft_pulse_w && !ev_ok_w
      |=> s_err_dark)
      else $error("soft reset left soft error lit");
   a_hard_holds: assert property ((err_q == FPI_ERR_HARD) |=> (err_q == FPI_ERR_HARD)
      ##1 o_error_lamp)
      else $error("hard error was cleared");
   a_no_err_dark: assert property ((err_q == FPI_ERR_IDLE) |=> !o_error_lamp)
      else $error("error lamp lit without error");
   a_bad_code: assert property ((err_q == FPI_ERR_IDLE) && i_err_event && !ev_ok_w
      |=> (err_q == FPI_ERR_IDLE))
      else $error("invalid error code accepted");

   // ==========================================================
   // display selection
   logic [3:0] nib_w [FPI_DIGITS];
   logic blank_w [FPI_DIGITS];
   logic show_err_w;
   logic [3:0] unit_dig_w;
   logic [6:0] seg_q [FPI_DIGITS];

   assign show_err_w = err_q != FPI_ERR_IDLE;
   assign unit_dig_w = i_shutdown_halt ? FPI_HALT_DIGIT : unit_num_w;
   assign nib_w[2] = (show_err_w | unit_mode_w) ? unit_dig_w : i_cylinder[11:8];
   assign nib_w[1] = show_err_w ? code_q[7:4] : i_cylinder[7:4];
   assign nib_w[0] = show_err_w ? code_q[3:0] : i_cylinder[3:0];
   assign blank_w[2] = 1'b0;
   assign blank_w[1] = unit_mode_w & ~show_err_w;
   assign blank_w[0] = unit_mode_w & ~show_err_w;

   genvar gi;
   generate
      for (gi = 0; gi < FPI_DIGITS; gi++)
      begin : g_digit
         always_ff @(posedge i_sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               seg_q[gi] <= FPI_SEG_BLANK;
            else
               seg_q[gi] <= blank_w[gi] ? FPI_SEG_BLANK : hex_to_seg(nib_w[gi]);
         end
      end
   endgenerate

   assign o_seg_unit = seg_q[2];
   assign o_seg_status_hi = seg_q[1];
   assign o_seg_status_lo = seg_q[0];
   a_err_code_shown: assert property (o_error_lamp |-> (o_seg_status_hi
      == hex_to_seg($past(code_q[7:4]))) && (o_seg_status_lo
      == hex_to_seg($past(code_q[3:0]))))
      else $error("error code not on digits");
   a_halt_digit: assert property (i_shutdown_halt && unit_mode_w
      |=> o_seg_unit == hex_to_seg(FPI_HALT_DIGIT))
      else $error("halt code not shown");
   a_cyl_shown: assert property (rst_n && !unit_mode_w && !show_err_w
      |=> (o_seg_status_lo == hex_to_seg($past(i_cylinder[3:0])))
      && !o_unit_mode_lamp)
      else $error("cylinder digits wrong");

   // ==========================================================
   // lamps
   logic protect_d;
   logic pfault_d;

   assign protect_d = ~(permit_w & ~ctrl_q[FPI_CTRL_PROT_BIT]);
   assign pfault_d = ac_w & (~pwr_w | dcf_q);

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_protect_lamp <= 1'b1;
         o_power_fault_lamp <= 1'b0;
         o_unit_mode_lamp <= 1'b0;
         o_error_lamp <= 1'b0;
      end
      else
      begin
         o_protect_lamp <= protect_d;
         o_power_fault_lamp <= pfault_d;
         o_unit_mode_lamp <= unit_mode_w;
         o_error_lamp <= show_err_w;
      end
   end
   a_protect_dark: assert property (permit_w && !ctrl_q[FPI_CTRL_PROT_BIT]
      |=> !o_protect_lamp)
      else $error("protect lamp lit while writable");
   a_fault_ac_off: assert property (ac_w && !pwr_w |=> o_power_fault_lamp)
      else $error("power fault lamp dark with switch off");
   a_fault_held: assert property (pwr_w && dcf_q && ac_w
      |=> o_power_fault_lamp)
      else $error("dc fault not shown");
   a_unit_lamp: assert property (unit_mode_w |=> o_unit_mode_lamp)
      else $error("unit lamp does not follow switches");

   // ==========================================================
   // interrupts and apb slave
   assign iset_w = {(err_q == FPI_ERR_SOFT) & soft_pulse_w & ~ev_ok_w,
      i_err_event & ~ev_ok_w, dcf_d & ~dcf_q, ev_ok_w};
   // set wins over a write-one clear in the same cycle
   assign istat_d = (istat_q & ~((wr_w && addr_hit(i_paddr, FPI_IRQ_STAT_OFF))
      ? i_pwdata[FPI_IRQ_W-1:0] : FPI_IRQ_RST)) | iset_w;
   assign stat_w = {9'h000, pin_q, code_q, i_shutdown_halt, dcf_q, err_q,
      o_error_lamp, o_unit_mode_lamp, o_power_fault_lamp, o_protect_lamp};
   assign rd_w = addr_hit(i_paddr, FPI_CTRL_OFF) ? {24'h00_0000, ctrl_q}
      : addr_hit(i_paddr, FPI_STAT_OFF) ? stat_w
      : addr_hit(i_paddr, FPI_IRQ_STAT_OFF) ? {28'h000_0000, istat_q}
      : addr_hit(i_paddr, FPI_IRQ_MASK_OFF) ? {28'h000_0000, imask_q}
      : 32'h0000_0000;

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= FPI_CTRL_RST;
         imask_q <= FPI_IRQ_RST;
         istat_q <= FPI_IRQ_RST;
         o_irq <= 1'b0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         if (wr_w && addr_hit(i_paddr, FPI_CTRL_OFF))
            ctrl_q <= i_pwdata[7:0];
         if (wr_w && addr_hit(i_paddr, FPI_IRQ_MASK_OFF))
            imask_q <= i_pwdata[FPI_IRQ_W-1:0];
         istat_q <= istat_d;
         o_irq <= |(istat_q & imask_q);
         o_pready <= setup_w;
         o_pslverr <= setup_w & ~mapped_w;
         o_prdata <= setup_w ? rd_w : 32'h0000_0000;
      end
   end

   a_irq_level: assert property (|(istat_q & imask_q) |=> o_irq)
      else $error("irq not raised");
   a_apb_one_wait: assert property (setup_w |=> o_pready ##1 !o_pready)
      else $error("apb answer timing wrong");

endmodule

`default_nettype wire

// ---- verification/fpi_operator.sv ----
// operator model that reads the panel digits back into hex symbols
`timescale 1ns/10ps
`default_nettype none
module fpi_operator
   import fpi_pkg::*;
(
   input wire logic [6:0] i_seg_unit,
   input wire logic [6:0] i_seg_status_hi,
   input wire logic [6:0] i_seg_status_lo,
   output logic [4:0] o_read_unit,
   output logic [4:0] o_read_hi,
   output logic [4:0] o_read_lo
);
   // ==========================================================
   // glyph recognition: 5'h10 blank, 5'h1F unreadable
   localparam logic [6:0] GLYPH [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
      7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

   function automatic logic [4:0] read_glyph(input logic [6:0] s);
      logic [4:0] r;
      r = (s === FPI_SEG_BLANK) ? 5'h10 : 5'h1F;
      for (int i = 0; i < 16; i++)
      begin
         if (s === GLYPH[i])
         begin
            r = {1'b0, 4'(i)};
         end
      end
      return r;
   endfunction

   assign o_read_unit = read_glyph(i_seg_unit);
   assign o_read_hi = read_glyph(i_seg_status_hi);
   assign o_read_lo = read_glyph(i_seg_status_lo);
endmodule
`default_nettype wire

// ---- verification/fpi_panel_tb.sv ----
// self-checking bench for the front panel indicator block
`timescale 1ns/10ps
`default_nettype none
module fpi_panel_tb import fpi_pkg::*;;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [11:0] paddr = '0, cyl = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic permit = 0, ac = 0, dc = 0, sw = 0, sela = 0, selb = 0, srst = 0;
   logic ev = 0, hard = 0, halt = 0, prot, pfl, unl, errl, irq;
   logic [7:0] code = '0;
   logic [6:0] su, sh, sl;
   logic [4:0] ru, rh, rl;
   logic [7:0] codes[$] = '{8'h20, 8'hDD, 8'h1F, 8'hE0, 8'h2F, 8'hA5};
   int mismatches = 0, comparisons = 0, seed = 44;
   int m_err = 0, m_code = 0, m_unit = 0, m_force = 0, m_latch = 0, m_irq = 0;

   always #2.5 clk = ~clk;

   fpi_panel dut (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_write_permit(permit), .i_ac_power_ok(ac),
      .i_dc_power_ok(dc), .i_power_switch_on(sw), .i_display_select_switch_a(sela),
      .i_display_select_switch_b(selb), .i_ctl_soft_reset(srst), .i_err_event(ev),
      .i_err_hard(hard), .i_err_code(code), .i_shutdown_halt(halt), .i_cylinder(cyl),
      .o_protect_lamp(prot), .o_power_fault_lamp(pfl), .o_unit_mode_lamp(unl),
      .o_error_lamp(errl), .o_seg_unit(su), .o_seg_status_hi(sh), .o_seg_status_lo(sl),
      .o_irq(irq));

   fpi_operator op (.i_seg_unit(su), .i_seg_status_hi(sh), .i_seg_status_lo(sl),
      .o_read_unit(ru), .o_read_hi(rh), .o_read_lo(rl));

   // ==========================================================
   // comparison, verdict and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // ==========================================================
   // stimulus tasks that also advance the model
   task automatic pins(input logic [5:0] p);
      {permit, ac, dc, sw, sela, selb} <= p;
      repeat (8) @(posedge clk);
      if (!p[2])
         m_latch = 0;
      else if (p[4] && !p[3])
      begin
         m_latch = 1;
         m_irq |= 2;
      end
   endtask

   task automatic event_in(input logic h, input logic [7:0] c);
      ev <= 1'b1;
      hard <= h;
      code <= c;
      @(posedge clk);
      ev <= 1'b0;
      repeat (4) @(posedge clk);
      if (c < 8'h20 || c > 8'hDD || c[3:0] > 4'hE || c[7:4] > 4'hE)
         m_irq |= 4;
      else
      begin
         m_err = h ? 3 : 1;
         m_code = c;
         m_irq |= 1;
      end
   endtask

   task automatic soft_reset;
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      if (m_err == 1)
      begin
         m_err = 0;
         m_irq |= 8;
      end
   endtask

   task automatic chk_panel;
      logic [11:0] v;
      logic um;
      um = sela && !selb;
      v = (m_err != 0 || um) ? {halt ? 4'hF : 4'(m_unit), 8'(m_code)} : cyl;
      chk(32'({prot, pfl, unl, errl}), 32'({!(permit && m_force == 0),
         (ac && !sw) || m_latch != 0, um, m_err != 0}));
      chk(32'({ru, rh, rl}), 32'({1'b0, v[11:8], (m_err == 0 && um) ? 10'h210 :
         {1'b0, v[7:4], 1'b0, v[3:0]}}));
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      codes.push_back(8'($random(seed)));
      repeat (8) @(posedge clk);
      chk(32'({prot, pfl, unl, errl, su, sh, sl}), 32'h0100_0000);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b1, FPI_CTRL_OFF, 32'h0000_0050);
      m_unit = 5;
      apb(1'b0, FPI_CTRL_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0050);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      pins(6'b011000);
      chk_panel;
      pins(6'b111110);
      chk_panel;
      pins(6'b110110);
      chk_panel;
      pins(6'b111110);
      chk_panel;
      pins(6'b111010);
      pins(6'b111110);
      chk_panel;
      for (int i = 0; i < 4; i++)
      begin
         m_unit = $random(seed) & 15;
         m_force = i & 1;
         cyl <= 12'($random(seed));
         apb(1'b1, FPI_CTRL_OFF, 32'(m_unit * 16 + m_force));
         pins({4'b1111, 2'(i)});
         chk_panel;
      end
      halt <= 1'b1;
      pins(6'b111110);
      chk_panel;
      halt <= 1'b0;
      pins(6'b111100);
      foreach (codes[i])
      begin
         event_in(1'b0, codes[i]);
         chk_panel;
         soft_reset;
         chk_panel;
      end
      event_in(1'b1, 8'h3C);
      event_in(1'b1, 8'h4B);
      soft_reset;
      chk_panel;
      apb(1'b0, FPI_STAT_OFF, 32'h0000_0000);
      chk(rd, 32'({9'h000, srst, selb, sela, sw, dc, ac, permit, 8'(m_code), halt,
         m_latch != 0, 2'(m_err), m_err != 0, sela && !selb, (ac && !sw) || m_latch != 0,
         !(permit && m_force == 0)}));
      chk(32'(er), 32'h0000_0000);
      apb(1'b0, FPI_IRQ_STAT_OFF, 32'h0000_0000);
      chk(rd, 32'(m_irq));
      apb(1'b1, FPI_IRQ_MASK_OFF, 32'h0000_000F);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b1, FPI_IRQ_STAT_OFF, 32'h0000_000F);
      repeat (2) @(posedge clk);
      apb(1'b0, FPI_IRQ_STAT_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      give_verdict;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict;
   end
endmodule
`default_nettype wire
